/* File: hdl/frtc_pkg.sv */
// constants and types of the frame timing configuration slice
package frtc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register word offsets
    localparam logic [7:0] OFS_REGION_UPPER = 8'h04;
    localparam logic [7:0] OFS_DARK_ROW = 8'h05;
    localparam logic [7:0] OFS_PADDING_ROW = 8'h06;
    localparam logic [7:0] OFS_TIME_BASE = 8'h07;
    localparam logic [7:0] OFS_FRAME_DURATION = 8'h08;
    localparam logic [7:0] OFS_INTEGRATION = 8'h09;
    localparam logic [7:0] OFS_SPARE_A = 8'h0a;
    localparam logic [7:0] OFS_FIRST = OFS_REGION_UPPER;
    localparam logic [7:0] OFS_LAST = OFS_SPARE_A;
    localparam int NUM_WORDS = 7;

    // word indices inside the slice
    localparam int IDX_REGION_UPPER = 0;
    localparam int IDX_DARK_ROW = 1;
    localparam int IDX_PADDING_ROW = 2;
    localparam int IDX_TIME_BASE = 3;
    localparam int IDX_FRAME_DURATION = 4;
    localparam int IDX_INTEGRATION = 5;
    localparam int IDX_SPARE_A = 6;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset and writable bits, index 6 first
    localparam logic [6:0][15:0] WORD_RESET = {
        16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0102, 16'h0000};
    localparam logic [6:0][15:0] WORD_MASK = {
        16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0fff, 16'h01ff, 16'hff80};

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int REGION_LSB = 7;
    localparam int REGION_MSB = 15;
    localparam int REGION_COUNT = 9;
    localparam int DARK_COUNT_MSB = 7;
    localparam int BLANK_FIRST_BIT = 8;
    localparam int PADDING_MSB = 11;
    localparam logic [7:0] DARK_COUNT_MIN = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // time base unit: 1/62 MHz, counted on the 50 MHz reference clock
    localparam int UNIT_FREQ_KHZ = 62000;
    localparam int REF_CLK_KHZ = 50000;
    localparam int UNIT_PERIOD_PS = 1000000000 / UNIT_FREQ_KHZ;
    localparam int REF_PERIOD_PS = 1000000000 / REF_CLK_KHZ;
    localparam int UNIT_CYCLES_RAW = UNIT_PERIOD_PS / REF_PERIOD_PS;
    localparam int UNIT_CYCLES = (UNIT_CYCLES_RAW < 1) ? 1 : UNIT_CYCLES_RAW;

    ////////////////////////////////////////////////////////////////////////////
    // settings presented to the readout sequencer
    typedef struct packed {
        logic [8:0] region_enable;
        logic [7:0] dark_line_count;
        logic blank_first_line;
        logic [11:0] padding_line_count;
        logic [15:0] time_base;
        logic [15:0] reset_length;
        logic [15:0] frame_length;
        logic [15:0] exposure_lines;
        logic [15:0] exposure_units;
    } frtc_cfg_t;

endpackage

/* File: hdl/frtc_reg_word.sv */
// one configuration word with reset value and writable-bit mask
`timescale 1ns/10ps
module frtc_reg_word #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0,
    parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] word_out
);

    logic [WIDTH-1:0] word_d;
    logic [WIDTH-1:0] word_q;

    // bits outside the mask stay at zero
    assign word_d = wr_en_in ? (wdata_in & WRITE_MASK) : word_q;
    assign word_out = word_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            word_q <= RESET_VALUE;
        end else begin
            word_q <= word_d;
        end
    end

endmodule

/* File: hdl/frtc_unit_timer.sv */
// time base unit tick generator for global shutter timing
`timescale 1ns/10ps
module frtc_unit_timer #(
    parameter int UNIT_CYCLES = frtc_pkg::UNIT_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic [15:0] time_base_in,
    output logic unit_tick_out
);

    logic [15:0] step_d;
    logic [15:0] step_q;
    logic [15:0] units_d;
    logic [15:0] units_q;
    logic tick_d;
    logic tick_q;
    logic step_done;
    logic units_done;

    // a time base of zero behaves as one unit
    assign step_done = (step_q >= 16'(UNIT_CYCLES - 1));
    assign units_done = step_done && ((units_q + 16'h0001) >= time_base_in);
    assign step_d = (!enable_in || step_done) ? 16'h0000 : step_q + 16'h0001;
    assign units_d = (!enable_in || units_done) ? 16'h0000 :
                     (step_done ? units_q + 16'h0001 : units_q);
    assign tick_d = enable_in && units_done;
    assign unit_tick_out = tick_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            step_q <= 16'h0000;
            units_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            step_q <= step_d;
            units_q <= units_d;
            tick_q <= tick_d;
        end
    end

endmodule

/* File: hdl/frtc_config_regs.sv */
// frame timing configuration register slice of the readout sequencer
//
// Overview of operation
// - Bits 7 to 15 of the upper enable word switch regions 23 to 31 on when 1 and off when 0.
// - The dark line word bits 7 to 0 give the dark reference lines per frame, range 1 to 255, reset 2.
// - Dark line word bit 8 blanks the first output line when 1, resets to 1.
// - Only in rolling shutter the 12-bit padding field adds 0 to 4095 padding lines, reset 0.
// - Only in global shutter the 16-bit time base, reset 1, is the step of exposure and reset timing in 1/62 MHz units.
// - Only in global shutter the duration field is a reset length when the select is 0 and a frame length when 1.
// - Exposure counts lines in rolling shutter and time base units in global shutter, reset 0.
`timescale 1ns/10ps
module frtc_config_regs (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_en_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rd_valid_out,
    input wire logic global_shutter_in,
    input wire logic duration_meaning_select_in,
    input wire logic timer_run_in,
    output frtc_pkg::frtc_cfg_t cfg_out,
    output logic unit_tick_out
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [6:0][15:0] word_val;
    logic [7:0] word_index_raw;
    logic [2:0] word_index;
    logic addr_hit;

    assign addr_hit = (reg_addr_in >= frtc_pkg::OFS_FIRST) && (reg_addr_in <= frtc_pkg::OFS_LAST);
    assign word_index_raw = reg_addr_in - frtc_pkg::OFS_FIRST;
    assign word_index = word_index_raw[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // storage words

    genvar gi;
    generate
        for (gi = 0; gi < frtc_pkg::NUM_WORDS; gi = gi + 1) begin : g_word
            logic word_wr_en;

            // unused bits are masked to zero on write
            assign word_wr_en = reg_wr_en_in && addr_hit && (word_index == 3'(gi));

            frtc_reg_word #(
                .WIDTH(16),
                .RESET_VALUE(frtc_pkg::WORD_RESET[gi]),
                .WRITE_MASK(frtc_pkg::WORD_MASK[gi])
            ) u_word (
                .ref_clk_in(ref_clk_in),
                .reset_n_in(reset_n_in),
                .wr_en_in(word_wr_en),
                .wdata_in(reg_wdata_in),
                .word_out(word_val[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path, one cycle latency, unmapped reads zero

    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic rd_valid_q;

    assign rdata_d = !reg_rd_en_in ? rdata_q : (addr_hit ? word_val[word_index] : 16'h0000);
    assign reg_rdata_out = rdata_q;
    assign reg_rd_valid_out = rd_valid_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rd_valid_q <= reg_rd_en_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    logic [15:0] region_word;
    logic [15:0] dark_word;
    logic [15:0] padding_word;
    logic [15:0] time_base_word;
    logic [15:0] duration_word;
    logic [15:0] integration_word;
    logic [7:0] dark_count_raw;

    assign region_word = word_val[frtc_pkg::IDX_REGION_UPPER];
    assign dark_word = word_val[frtc_pkg::IDX_DARK_ROW];
    assign padding_word = word_val[frtc_pkg::IDX_PADDING_ROW];
    assign time_base_word = word_val[frtc_pkg::IDX_TIME_BASE];
    assign duration_word = word_val[frtc_pkg::IDX_FRAME_DURATION];
    assign integration_word = word_val[frtc_pkg::IDX_INTEGRATION];
    assign dark_count_raw = dark_word[frtc_pkg::DARK_COUNT_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    // effective settings for the sequencer

    frtc_pkg::frtc_cfg_t cfg_d;
    frtc_pkg::frtc_cfg_t cfg_q;
    logic shutter_rolling;
    logic select_reset;
    logic select_frame;

    assign shutter_rolling = !global_shutter_in;
    assign select_reset = global_shutter_in && !duration_meaning_select_in;
    assign select_frame = global_shutter_in && duration_meaning_select_in;

    // one enable per region, 1 includes it in readout
    generate
        for (gi = 0; gi < frtc_pkg::REGION_COUNT; gi = gi + 1) begin : g_region
            assign cfg_d.region_enable[gi] = region_word[frtc_pkg::REGION_LSB + gi];
        end
    endgenerate

    // zero is outside the valid range, read as the minimum
    assign cfg_d.dark_line_count = (dark_count_raw == 8'h00) ? frtc_pkg::DARK_COUNT_MIN : dark_count_raw;
    assign cfg_d.blank_first_line = dark_word[frtc_pkg::BLANK_FIRST_BIT];
    assign cfg_d.padding_line_count = shutter_rolling ? padding_word[frtc_pkg::PADDING_MSB:0] : 12'h000;
    assign cfg_d.time_base = global_shutter_in ? time_base_word : 16'h0000;
    assign cfg_d.reset_length = select_reset ? duration_word : 16'h0000;
    assign cfg_d.frame_length = select_frame ? duration_word : 16'h0000;
    assign cfg_d.exposure_lines = shutter_rolling ? integration_word : 16'h0000;
    assign cfg_d.exposure_units = global_shutter_in ? integration_word : 16'h0000;
    assign cfg_out = cfg_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time base unit ticks, global shutter only

    logic timer_enable;

    assign timer_enable = timer_run_in && global_shutter_in;

    frtc_unit_timer #(
        .UNIT_CYCLES(frtc_pkg::UNIT_CYCLES)
    ) u_unit_timer (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .enable_in(timer_enable),
        .time_base_in(time_base_word),
        .unit_tick_out(unit_tick_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    logic wr_region;
    logic wr_dark;
    logic wr_duration;
    logic wr_integration;
    logic wr_padding;
    logic wr_time_base;

    assign wr_region = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_REGION_UPPER);
    assign wr_dark = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_DARK_ROW);
    assign wr_duration = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_FRAME_DURATION);
    assign wr_integration = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_INTEGRATION);
    assign wr_padding = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_PADDING_ROW);
    assign wr_time_base = reg_wr_en_in && (reg_addr_in == frtc_pkg::OFS_TIME_BASE);

    a_region_enable_map: assert property (
        wr_region ##1 !wr_region |=>
        cfg_out.region_enable == $past(reg_wdata_in[15:7], 2))
    else $error("region enables do not follow the written word");

    a_dark_count_write: assert property (
        wr_dark && (reg_wdata_in[7:0] != 8'h00) ##1 !wr_dark |=>
        cfg_out.dark_line_count == $past(reg_wdata_in[7:0], 2))
    else $error("dark line count does not follow the written value");

    // first edge after reset still shows the cleared settings
    a_dark_count_floor: assert property (
        $past(reset_n_in) |-> cfg_out.dark_line_count != 8'h00)
    else $error("dark line count fell below one");

    a_blank_first_line: assert property (
        wr_dark ##1 !wr_dark |=>
        cfg_out.blank_first_line == $past(reg_wdata_in[8], 2))
    else $error("first line blanking does not follow bit 8");

    a_padding_rolling_only: assert property (
        global_shutter_in |=> cfg_out.padding_line_count == 12'h000)
    else $error("padding lines present in global shutter");

    a_tick_spacing: assert property (
        unit_tick_out && timer_enable && $stable(time_base_word) && (time_base_word > 16'h0001)
        |=> !unit_tick_out)
    else $error("time base tick repeated too soon");

    a_tick_needs_enable: assert property (
        !global_shutter_in ##1 !global_shutter_in |=> !unit_tick_out)
    else $error("time base tick outside global shutter");

    a_duration_select: assert property (
        wr_duration && global_shutter_in && !duration_meaning_select_in ##1
        (global_shutter_in && !duration_meaning_select_in && !wr_duration) |=>
        (cfg_out.reset_length == $past(reg_wdata_in, 2)) && (cfg_out.frame_length == 16'h0000))
    else $error("duration not read as reset length");

    a_exposure_split: assert property (
        wr_integration && !global_shutter_in ##1 (!global_shutter_in && !wr_integration) |=>
        (cfg_out.exposure_lines == $past(reg_wdata_in, 2)) && (cfg_out.exposure_units == 16'h0000))
    else $error("exposure not read as lines in rolling shutter");

    a_read_unmapped: assert property (
        reg_rd_en_in && !addr_hit |=> reg_rd_valid_out && (reg_rdata_out == 16'h0000))
    else $error("unmapped read did not answer zero");

    a_region_hold: assert property (
        !wr_region ##1 !wr_region |=> $stable(cfg_out.region_enable))
    else $error("region enables moved without a write");

    a_region_low_bits: assert property (
        reg_rd_en_in && (reg_addr_in == frtc_pkg::OFS_REGION_UPPER) |=> reg_rdata_out[6:0] == 7'h00)
    else $error("unused region word bits read back set");

    a_dark_zero_floor: assert property (
        wr_dark && (reg_wdata_in[7:0] == 8'h00) ##1 !wr_dark |=>
        cfg_out.dark_line_count == frtc_pkg::DARK_COUNT_MIN)
    else $error("dark line count zero not read as one");

    a_dark_hold: assert property (
        !wr_dark ##1 !wr_dark |=> $stable(cfg_out.dark_line_count) && $stable(cfg_out.blank_first_line))
    else $error("dark line settings moved without a write");

    a_dark_high_bits: assert property (
        reg_rd_en_in && (reg_addr_in == frtc_pkg::OFS_DARK_ROW) |=> reg_rdata_out[15:9] == 7'h00)
    else $error("unused dark line word bits read back set");

    a_padding_write: assert property (
        wr_padding && !global_shutter_in ##1 (!global_shutter_in && !wr_padding) |=>
        cfg_out.padding_line_count == $past(reg_wdata_in[11:0], 2))
    else $error("padding lines do not follow the written value");

    a_padding_high_bits: assert property (
        reg_rd_en_in && (reg_addr_in == frtc_pkg::OFS_PADDING_ROW) |=> reg_rdata_out[15:12] == 4'h0)
    else $error("unused padding word bits read back set");

    a_time_base_write: assert property (
        wr_time_base && global_shutter_in ##1 (global_shutter_in && !wr_time_base) |=>
        cfg_out.time_base == $past(reg_wdata_in, 2))
    else $error("time base does not follow the written value");

    a_time_base_rolling: assert property (
        !global_shutter_in |=> cfg_out.time_base == 16'h0000)
    else $error("time base present in rolling shutter");

    a_tick_unit_one: assert property (
        (frtc_pkg::UNIT_CYCLES == 1) && timer_enable && (time_base_word <= 16'h0001) |=> unit_tick_out)
    else $error("time base of one did not tick every cycle");

    a_tick_stops: assert property (
        !timer_run_in |=> !unit_tick_out)
    else $error("time base tick without a run request");

    a_duration_rolling: assert property (
        !global_shutter_in |=> (cfg_out.reset_length == 16'h0000) && (cfg_out.frame_length == 16'h0000))
    else $error("duration present in rolling shutter");

    a_reset_length_off: assert property (
        global_shutter_in && duration_meaning_select_in |=> cfg_out.reset_length == 16'h0000)
    else $error("reset length present in frame length mode");

    a_frame_length_off: assert property (
        global_shutter_in && !duration_meaning_select_in |=> cfg_out.frame_length == 16'h0000)
    else $error("frame length present in reset length mode");

    a_frame_length_write: assert property (
        wr_duration && global_shutter_in && duration_meaning_select_in ##1
        (global_shutter_in && duration_meaning_select_in && !wr_duration) |=>
        cfg_out.frame_length == $past(reg_wdata_in, 2))
    else $error("duration not read as frame length");

    a_exposure_units: assert property (
        wr_integration && global_shutter_in ##1 (global_shutter_in && !wr_integration) |=>
        (cfg_out.exposure_units == $past(reg_wdata_in, 2)) && (cfg_out.exposure_lines == 16'h0000))
    else $error("exposure not read as time base units in global shutter");

    a_exposure_units_rolling: assert property (
        !global_shutter_in |=> cfg_out.exposure_units == 16'h0000)
    else $error("exposure units present in rolling shutter");

    a_exposure_lines_global: assert property (
        global_shutter_in |=> cfg_out.exposure_lines == 16'h0000)
    else $error("exposure lines present in global shutter");

    a_unmapped_write: assert property (
        reg_wr_en_in && !addr_hit |=> $stable(word_val))
    else $error("unmapped write changed a stored word");

endmodule

/* File: verif/frtc_host_model.sv */
// host controller model driving the configuration word port
`timescale 1ns/10ps
module frtc_host_model (
    input wire logic ref_clk_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_en_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_rd_en_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rd_valid_in
);
    int gap = 0;

    initial begin
        reg_addr_out = 8'h00;
        reg_wr_en_out = 1'b0;
        reg_wdata_out = 16'h0000;
        reg_rd_en_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // released address and data lines show the inverse of their last value; both enables go low
    task automatic release_bus();
        reg_wr_en_out = 1'b0;
        reg_rd_en_out = 1'b0;
        reg_addr_out = ~reg_addr_out;
        reg_wdata_out = ~reg_wdata_out;
    endtask

    task automatic idle();
        repeat (gap) @(posedge ref_clk_in);
        @(posedge ref_clk_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // used selects the bits the host may set; others go out as zero
    task automatic write_word(input logic [7:0] addr, input logic [15:0] data, input logic [15:0] used);
        idle();
        reg_addr_out = addr;
        reg_wdata_out = data & used;
        reg_wr_en_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        release_bus();
    endtask

    task automatic read_word(input logic [7:0] addr, output logic [15:0] data, output logic valid);
        idle();
        reg_addr_out = addr;
        reg_rd_en_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        data = reg_rdata_in;
        valid = reg_rd_valid_in;
        release_bus();
    endtask
endmodule

/* File: verif/frtc_config_regs_test.sv */
// self-checking bench of the frame timing configuration slice
`timescale 1ns/10ps
module frtc_config_regs_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic shutter_global = 1'b0;
    logic sel = 1'b0;
    logic timer_run = 1'b0;
    logic [7:0] addr;
    logic wr_en;
    logic [15:0] wdata;
    logic rd_en;
    logic [15:0] rdata;
    logic rd_valid;
    logic unit_tick;
    frtc_pkg::frtc_cfg_t cfg;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    frtc_host_model host (.ref_clk_in(clk), .reg_addr_out(addr), .reg_wr_en_out(wr_en),
        .reg_wdata_out(wdata), .reg_rd_en_out(rd_en), .reg_rdata_in(rdata), .reg_rd_valid_in(rd_valid));

    frtc_config_regs dut (.ref_clk_in(clk), .reset_n_in(reset_n), .reg_addr_in(addr), .reg_wr_en_in(wr_en),
        .reg_wdata_in(wdata), .reg_rd_en_in(rd_en), .reg_rdata_out(rdata), .reg_rd_valid_out(rd_valid),
        .global_shutter_in(shutter_global), .duration_meaning_select_in(sel), .timer_run_in(timer_run),
        .cfg_out(cfg), .unit_tick_out(unit_tick));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check_value(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host.read_word(a, d, v);
        check_value("read valid", 16'h0001, 16'(v));
        check_value("read data", exp, d);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        logic [15:0] exp [7] = '{16'h0000, 16'h0102, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            read_check(8'h04 + 8'(i), exp[i]);
        end
        check_value("dark count", 16'h0002, 16'(cfg.dark_line_count));
        check_value("blank first", 16'h0001, 16'(cfg.blank_first_line));
        host.write_word(8'h03, 16'hffff, 16'hffff);
        read_check(8'h03, 16'h0000);
        read_check(8'h0b, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_masks();
        logic [15:0] exp [7] = '{16'hff80, 16'h01ff, 16'h0fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
        host.gap = 2;
        for (int i = 0; i < 7; i++) begin
            host.write_word(8'h04 + 8'(i), 16'hffff, 16'hffff);
        end
        for (int i = 0; i < 7; i++) begin
            read_check(8'h04 + 8'(i), exp[i]);
        end
        host.gap = 0;
        host.write_word(frtc_pkg::OFS_SPARE_A, 16'h0000, 16'hffff);
        settle();
        check_value("regions all", 16'h01ff, 16'(cfg.region_enable));
        $display("test masks done");
    endtask

    task automatic test_regions();
        for (int i = 0; i < 9; i++) begin
            host.write_word(frtc_pkg::OFS_REGION_UPPER, 16'h0080 << i, 16'hff80);
            settle();
            check_value("region enable", 16'h0001 << i, 16'(cfg.region_enable));
        end
        $display("test regions done");
    endtask

    task automatic test_dark();
        logic [15:0] w [3] = '{16'h0000, 16'h01ff, 16'h0001};
        logic [15:0] c [3] = '{16'h0001, 16'h00ff, 16'h0001};
        for (int i = 0; i < 3; i++) begin
            host.write_word(frtc_pkg::OFS_DARK_ROW, w[i], 16'h01ff);
            settle();
            check_value("dark count", c[i], 16'(cfg.dark_line_count));
            check_value("blank first", 16'(w[i][8]), 16'(cfg.blank_first_line));
        end
        $display("test dark done");
    endtask

    task automatic test_modes();
        int ticks;
        host.write_word(frtc_pkg::OFS_PADDING_ROW, 16'h0fff, 16'h0fff);
        host.write_word(frtc_pkg::OFS_TIME_BASE, 16'h0005, 16'hffff);
        host.write_word(frtc_pkg::OFS_FRAME_DURATION, 16'h1234, 16'hffff);
        host.write_word(frtc_pkg::OFS_INTEGRATION, 16'h00aa, 16'hffff);
        for (int m = 0; m < 3; m++) begin
            shutter_global = (m != 0);
            sel = (m == 2);
            if (m != 0) begin
                // fresh values per global mode
                host.write_word(frtc_pkg::OFS_FRAME_DURATION, 16'h1230 + 16'(m), 16'hffff);
                host.write_word(frtc_pkg::OFS_INTEGRATION, 16'h00a0 + 16'(m), 16'hffff);
            end
            settle();
            check_value("padding", shutter_global ? 16'h0000 : 16'h0fff, 16'(cfg.padding_line_count));
            check_value("time base", shutter_global ? 16'h0005 : 16'h0000, cfg.time_base);
            check_value("reset length", (m == 1) ? 16'h1231 : 16'h0000, cfg.reset_length);
            check_value("frame length", (m == 2) ? 16'h1232 : 16'h0000, cfg.frame_length);
            check_value("exposure lines", shutter_global ? 16'h0000 : 16'h00aa, cfg.exposure_lines);
            check_value("exposure units", shutter_global ? 16'h00a0 + 16'(m) : 16'h0000, cfg.exposure_units);
        end
        shutter_global = 1'b0;
        timer_run = 1'b1;
        ticks = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            ticks += (unit_tick === 1'b1) ? 1 : 0;
        end
        timer_run = 1'b0;
        check_value("rolling ticks", 16'h0000, 16'(ticks));
        $display("test modes done");
    endtask

    task automatic tick_period(input logic [15:0] tb);
        int n;
        int t;
        n = 0;
        t = 0;
        shutter_global = 1'b1;
        host.write_word(frtc_pkg::OFS_TIME_BASE, tb, 16'hffff);
        timer_run = 1'b1;
        while (unit_tick !== 1'b1 && t < 100) begin
            @(posedge clk);
            #1;
            t++;
        end
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (unit_tick !== 1'b1 && n < 100);
        check_value("tick period", 16'(((tb == 16'h0000) ? 1 : int'(tb)) * frtc_pkg::UNIT_CYCLES), 16'(n));
        timer_run = 1'b0;
        $display("test tick period %0d done", tb);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        test_reset();
        test_masks();
        test_regions();
        test_dark();
        test_modes();
        tick_period(16'h0003);
        tick_period(16'h0001);
        tick_period(16'h0000);
        close_out();
    end
endmodule
